// File: hw/fbp_pkg.sv
// Overview of operation
// - lower area starts 32k below top, grows up
// - upper area ends at top, grows down
// - upper and lower areas never meet
// - protected program or erase refused, violation flag
// - mass erase only when fully unprotected
// - config loaded from stored bytes; ones unprotect
// - unlock bit zero protects whole array
// - high disable one leaves upper area open
// - high size selects 2k to 16k
// - low disable one leaves lower area open
// - low size selects 512 to 4k
// - normal writes may only clear bits
// - added protection lasts until next reset
// - stored bytes protected with upper area
// - special mode lets software set bits
// - one config per array, bank selected
package fbp_pkg;

   localparam int          NUM_BANKS       = 2;
   localparam int          ADDR_W          = 16;

   // register byte offsets
   localparam logic [7:0]  OFS_PROT        = 8'h00;
   localparam logic [7:0]  OFS_CONFIG      = 8'h04;
   localparam logic [7:0]  OFS_ADDR        = 8'h08;
   localparam logic [7:0]  OFS_CMD         = 8'h0c;
   localparam logic [7:0]  OFS_STATUS      = 8'h10;
   localparam logic [7:0]  OFS_MASK        = 8'h14;

   // protection config fields
   localparam int          BIT_UNLOCK      = 7;
   localparam int          BIT_SPARE       = 6;
   localparam int          BIT_HIGH_DIS    = 5;
   localparam int          POS_HIGH_SIZE   = 3;
   localparam int          BIT_LOW_DIS     = 2;
   localparam int          POS_LOW_SIZE    = 0;
   localparam logic [7:0]  PROT_RESET      = 8'hff;

   // config register fields
   localparam int          BIT_BANK_SEL    = 0;
   localparam int          BIT_SPECIAL     = 1;

   // status fields
   localparam int          BIT_VIOL        = 0;
   localparam int          BIT_DONE        = 1;
   localparam int          BIT_BUSY        = 7;
   localparam int          EVENT_W         = 2;

   // area geometry for a 64k array
   localparam logic [16:0] ARRAY_TOP_END   = 17'h10000;
   localparam logic [16:0] LOW_AREA_OFFSET = 17'h08000;
   localparam logic [16:0] LOW_BASE_SIZE   = 17'h00200;
   localparam logic [16:0] HIGH_BASE_SIZE  = 17'h00800;

   // array commands
   localparam logic [1:0]  CMD_NONE        = 2'h0;
   localparam logic [1:0]  CMD_PROGRAM     = 2'h1;
   localparam logic [1:0]  CMD_SECTOR      = 2'h2;
   localparam logic [1:0]  CMD_MASS        = 2'h3;

   typedef enum logic [1:0] {FBP_LOAD, FBP_IDLE, FBP_BUSY} fbp_state_t;

   typedef struct packed {
      logic [1:0]        cmd;
      logic              bank;
      logic [ADDR_W-1:0] addr;
   } fbp_op_t;

   typedef struct packed {
      fbp_state_t                  state;
      logic [NUM_BANKS-1:0][7:0]   prot;
      logic                        bank_sel;
      logic [ADDR_W-1:0]           target;
      logic [EVENT_W-1:0]          status;
      logic [EVENT_W-1:0]          mask;
      logic                        mode_meta;
      logic                        mode_sync;
      logic                        wr_pend;
      logic [7:0]                  wr_addr;
      logic [31:0]                 hrdata;
      logic                        irq;
      logic                        hreadyout;
      logic                        hresp;
      logic                        op_start;
      fbp_op_t                     op;
   } fbp_regs_t;

endpackage

// File: hw/fbp_flash_block_protection.sv
// The implementer's own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module fbp_flash_block_protection (
   input  wire  logic                                 hclk,
   input  wire  logic                                 hresetn,
   input  wire  logic                                 hsel,
   input  wire  logic [31:0]                          haddr,
   input  wire  logic [1:0]                           htrans,
   input  wire  logic                                 hwrite,
   input  wire  logic [2:0]                           hsize,
   input  wire  logic [31:0]                          hwdata,
   input  wire  logic                                 hready,
   output logic                                       hreadyout,
   output logic [31:0]                                hrdata,
   output logic                                       hresp,
   input  wire  logic [fbp_pkg::NUM_BANKS-1:0][7:0]   stored_prot_bytes,
   input  wire  logic                                 special_mode_async,
   output logic                                       op_start,
   output fbp_pkg::fbp_op_t                           op_req,
   input  wire  logic                                 op_done,
   output logic                                       irq
);
   import fbp_pkg::*;

   fbp_regs_t r;
   fbp_regs_t n;

   // one array: decode the current config against a target address
   function automatic logic addr_protected(input logic [7:0] cfg, input logic [ADDR_W-1:0] a);
      logic [16:0] low_lo;
      logic [16:0] low_hi;
      logic [16:0] high_lo;
      logic [16:0] ax;
      logic        hit;
      ax      = {1'b0, a};
      low_lo  = LOW_AREA_OFFSET;
      low_hi  = LOW_AREA_OFFSET + (LOW_BASE_SIZE << cfg[POS_LOW_SIZE +: 2]);
      high_lo = ARRAY_TOP_END - (HIGH_BASE_SIZE << cfg[POS_HIGH_SIZE +: 2]);
      // largest lower area ends at 0x9000, largest upper starts at 0xc000
      hit     = 1'b0;
      if (!cfg[BIT_UNLOCK]) begin
         hit = 1'b1;
      end else begin
         if (!cfg[BIT_HIGH_DIS] && ax >= high_lo) begin
            hit = 1'b1;
         end
         if (!cfg[BIT_LOW_DIS] && ax >= low_lo && ax < low_hi) begin
            hit = 1'b1;
         end
      end
      // spare bit is never looked at here
      return hit;
   endfunction

   function automatic logic mass_allowed(input logic [7:0] cfg);
      return cfg[BIT_UNLOCK] && cfg[BIT_HIGH_DIS] && cfg[BIT_LOW_DIS];
   endfunction

   logic        addr_ok;
   logic [7:0]  sel_prot;
   logic        viol;

   always_comb begin
      n           = r;
      n.op_start  = 1'b0;
      n.hrdata    = 32'h0000_0000;
      // zero wait states: every transfer completes in one data phase, always okay
      n.hreadyout = 1'b1;
      n.hresp     = 1'b0;
      n.mode_meta = special_mode_async;
      n.mode_sync = r.mode_meta;
      sel_prot    = r.prot[r.bank_sel];
      viol        = 1'b0;
      addr_ok     = hsel && htrans[1] && hready;

      // address phase: reads answer at the next edge, status clears on read
      n.wr_pend = 1'b0;
      if (addr_ok) begin
         if (hwrite) begin
            n.wr_pend = 1'b1;
            n.wr_addr = haddr[7:0];
         end else begin
            unique case (haddr[7:0])
               OFS_PROT:   n.hrdata = {24'h00_0000, sel_prot};
               OFS_CONFIG: n.hrdata = {30'h0, r.mode_sync, r.bank_sel};
               OFS_ADDR:   n.hrdata = {16'h0000, r.target};
               OFS_CMD:    n.hrdata = {30'h0, r.op.cmd};
               OFS_STATUS: begin
                  n.hrdata           = {24'h00_0000, 6'h00, r.status};
                  n.hrdata[BIT_BUSY] = (r.state != FBP_IDLE);
                  n.status           = '0;
               end
               OFS_MASK:   n.hrdata = {30'h0, r.mask};
               default:    n.hrdata = 32'h0000_0000;
            endcase
         end
      end

      // array sequencing; sets below here win over the read clear above
      unique case (r.state)
         FBP_LOAD: begin
            n.prot  = stored_prot_bytes;
            n.state = FBP_IDLE;
         end
         FBP_IDLE: begin
         end
         FBP_BUSY: begin
            if (op_done) begin
               n.state            = FBP_IDLE;
               n.status[BIT_DONE] = 1'b1;
            end
         end
      endcase

      // data phase of a write
      if (r.wr_pend) begin
         unique case (r.wr_addr)
            OFS_PROT: begin
               if (r.state != FBP_LOAD) begin
                  if (r.mode_sync) begin
                     n.prot[r.bank_sel] = hwdata[7:0];
                  end else begin
                     n.prot[r.bank_sel] = sel_prot & hwdata[7:0];
                  end
               end
            end
            OFS_CONFIG: n.bank_sel = hwdata[BIT_BANK_SEL];
            OFS_ADDR:   n.target   = hwdata[ADDR_W-1:0];
            OFS_CMD: begin
               // a command while busy or loading is dropped
               if (r.state == FBP_IDLE && hwdata[1:0] != CMD_NONE) begin
                  if (hwdata[1:0] == CMD_MASS) begin
                     viol = !mass_allowed(sel_prot);
                  end else begin
                     viol = addr_protected(sel_prot, r.target);
                  end
                  if (viol) begin
                     n.status[BIT_VIOL] = 1'b1;
                  end else begin
                     n.op_start = 1'b1;
                     n.op.cmd   = hwdata[1:0];
                     n.op.bank  = r.bank_sel;
                     n.op.addr  = r.target;
                     n.state    = FBP_BUSY;
                  end
               end
            end
            OFS_MASK:   n.mask = hwdata[EVENT_W-1:0];
            default: begin
            end
         endcase
      end

      n.irq = |(n.status & n.mask);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r.state     <= FBP_LOAD;
         r.prot      <= {NUM_BANKS{PROT_RESET}};
         r.bank_sel  <= 1'b0;
         r.target    <= '0;
         r.status    <= '0;
         r.mask      <= '0;
         r.mode_meta <= 1'b0;
         r.mode_sync <= 1'b0;
         r.wr_pend   <= 1'b0;
         r.wr_addr   <= 8'h00;
         r.hrdata    <= 32'h0000_0000;
         r.irq       <= 1'b0;
         r.hreadyout <= 1'b0;
         r.hresp     <= 1'b0;
         r.op_start  <= 1'b0;
         r.op        <= '0;
      end else begin
         r <= n;
      end
   end

   assign hreadyout = r.hreadyout;
   assign hresp     = r.hresp;
   assign hrdata    = r.hrdata;
   assign op_start  = r.op_start;
   assign op_req    = r.op;
   assign irq       = r.irq;

endmodule // fbp_flash_block_protection
`default_nettype wire

// File: test/fbp_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module fbp_monitor
   import fbp_pkg::*;
(
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        op_start,
   input wire fbp_op_t     op_req,
   input wire logic        op_done,
   input wire logic        irq
);
   logic        dp_wr;
   logic        dp_rd;
   logic [7:0]  dp_a;
   logic [15:0] tgt;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // bus data phase tracking, so checks can tie outputs to the write that caused them
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_wr <= 1'b0;
         dp_rd <= 1'b0;
         dp_a  <= 8'h00;
         tgt   <= 16'h0000;
      end else begin
         dp_wr <= hsel && htrans[1] && hready && hwrite;
         dp_rd <= hsel && htrans[1] && hready && !hwrite;
         if (hsel && htrans[1] && hready) dp_a <= haddr[7:0];
         if (dp_wr && dp_a == OFS_ADDR) tgt <= hwdata[15:0];
      end
   end
   sequence s_stat_rd;
      hsel && htrans[1] && hready && !hwrite && haddr[7:0] == OFS_STATUS;
   endsequence
   sequence s_quiet;
      !op_done && !(dp_wr && dp_a == OFS_CMD);
   endsequence
   property p_start_pulse; op_start |=> !op_start; endproperty
   property p_start_cause;
      op_start |-> $past(dp_wr && dp_a == OFS_CMD && hwdata[1:0] != CMD_NONE);
   endproperty
   property p_cmd_code; op_start |-> op_req.cmd == $past(hwdata[1:0]); endproperty
   property p_target; op_start |-> op_req.addr == tgt; endproperty
   property p_req_hold; !op_start |-> $stable(op_req); endproperty
   property p_irq_rise;
      $rose(irq) |-> $past(dp_wr && (dp_a == OFS_CMD || dp_a == OFS_MASK) || op_done);
   endproperty
   property p_irq_clear; s_stat_rd ##0 s_quiet |=> !irq; endproperty
   property p_rd_idle; !dp_rd |-> hrdata == 32'h0; endproperty
   property p_prot_byte; dp_rd && dp_a == OFS_PROT |-> hrdata[31:8] == 24'h0; endproperty
   a_start_pulse: assert property (p_start_pulse) else $error("launch longer than one cycle");
   a_start_cause: assert property (p_start_cause) else $error("launch without command");
   a_cmd_code: assert property (p_cmd_code) else $error("launched wrong command");
   a_target: assert property (p_target) else $error("launched wrong address");
   a_req_hold: assert property (p_req_hold) else $error("request moved");
   a_irq_rise: assert property (p_irq_rise) else $error("interrupt without event");
   a_irq_clear: assert property (p_irq_clear) else $error("interrupt stuck");
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside phase");
   a_prot_byte: assert property (p_prot_byte) else $error("config wider than byte");
endmodule // fbp_monitor
bind fbp_flash_block_protection fbp_monitor u_mon (.hclk, .hresetn, .hsel, .haddr, .htrans,
   .hwrite, .hwdata, .hready, .hrdata, .op_start, .op_req, .op_done, .irq);
`default_nettype wire

// File: test/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
   import fbp_pkg::*;
   logic                      hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic                      special_mode_async, op_start, op_done, irq;
   logic [31:0]               haddr, hwdata, hrdata;
   logic [1:0]                htrans;
   logic [NUM_BANKS-1:0][7:0] stored;
   fbp_op_t                   op_req;
   int                        n_fail, n_compared;
   fbp_flash_block_protection uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
      .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
      .stored_prot_bytes(stored), .special_mode_async, .op_start, .op_req, .op_done, .irq);
   initial begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end
   task automatic finish_test;
      if (n_fail == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // bounded wait: a stuck hreadyout ends the run instead of hanging it
   task automatic wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (n >= 20) begin
         n_fail++;
         finish_test();
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr  <= {24'h0, a};
      wait_rdy();
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      xfer(1'b1, a, d, x);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] x;
      xfer(1'b0, a, 32'h0, x);
      check(x, e);
   endtask
   // launch, expect refusal or a pulse, then complete it; viol is the only unmasked event
   task automatic run_cmd(input logic [15:0] a, input logic [1:0] c, input logic viol);
      wr(OFS_ADDR, {16'h0, a});
      wr(OFS_CMD, {30'h0, c});
      // the launch pulse stands only in the cycle right after the command data phase
      @(posedge hclk);
      check({31'h0, op_start}, {31'h0, !viol});
      @(posedge hclk);
      check({31'h0, op_start}, 32'h0);
      if (!viol) begin
         check({14'h0, op_req.cmd, op_req.addr}, {14'h0, c, a});
         op_done <= 1'b1;
         @(posedge hclk);
         op_done <= 1'b0;
      end
      check({31'h0, irq}, {31'h0, viol});
      rd_chk(OFS_STATUS, viol ? 32'h1 : 32'h2);
      check({31'h0, irq}, 32'h0);
   endtask
   initial begin
      {hsel, hwrite, op_done, special_mode_async} = 4'h0;
      {haddr, hwdata, htrans, n_fail, n_compared} = '0;
      stored = {8'hc2, 8'hff};
      hresetn = 1'b0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      rd_chk(OFS_PROT, 32'hff);
      rd_chk(8'h20, 32'h0);
      check({31'h0, hresp}, 32'h0);
      wr(8'h20, 32'hffff);
      wr(OFS_MASK, 32'h1);
      wr(OFS_CONFIG, 32'h1);
      rd_chk(OFS_PROT, 32'hc2);
      run_cmd(16'hf800, CMD_PROGRAM, 1'b1);
      run_cmd(16'hf7ff, CMD_SECTOR, 1'b0);
      run_cmd(16'hff0d, CMD_PROGRAM, 1'b1);
      run_cmd(16'h87ff, CMD_PROGRAM, 1'b1);
      run_cmd(16'h8800, CMD_PROGRAM, 1'b0);
      run_cmd(16'h7fff, CMD_SECTOR, 1'b0);
      run_cmd(16'h0000, CMD_MASS, 1'b1);
      wr(OFS_PROT, 32'hff);
      rd_chk(OFS_PROT, 32'hc2);
      wr(OFS_PROT, 32'h40);
      rd_chk(OFS_PROT, 32'h40);
      run_cmd(16'h1234, CMD_PROGRAM, 1'b1);
      wr(OFS_CONFIG, 32'h0);
      run_cmd(16'h0000, CMD_MASS, 1'b0);
      special_mode_async <= 1'b1;
      repeat (3) @(posedge hclk);
      rd_chk(OFS_CONFIG, 32'h2);
      // size codes are not monotonic in bits, so only special mode can walk all four
      for (int i = 3; i >= 0; i--) begin
         wr(OFS_PROT, {24'h0, 8'hc7 | 8'(i << 3)});
         run_cmd(16'h0 - (16'h800 << i), CMD_PROGRAM, 1'b1);
         run_cmd(16'hffff - (16'h800 << i), CMD_PROGRAM, 1'b0);
      end
      for (int i = 0; i < 4; i++) begin
         wr(OFS_PROT, {24'h0, 8'hf8 | 8'(i)});
         rd_chk(OFS_PROT, {24'h0, 8'hf8 | 8'(i)});
         run_cmd(16'h7fff + (16'h200 << i), CMD_PROGRAM, 1'b1);
         run_cmd(16'h8000 + (16'h200 << i), CMD_PROGRAM, 1'b0);
      end
      wr(OFS_PROT, 32'hdb);
      run_cmd(16'hbfff, CMD_PROGRAM, 1'b0);
      rd_chk(OFS_PROT, 32'hdb);
      special_mode_async <= 1'b0;
      hresetn <= 1'b0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      rd_chk(OFS_PROT, 32'hff);
      finish_test();
   end
endmodule // tb
`default_nettype wire
